// ---- hkc_keyscan.sv ----
/*
  headset keyscan control: press settle, press mask timeout, mic check,
  key value compression and impedance threshold compare, with its register bytes.
  assumes a decoded byte register port behind the serial control interface,
  a same-clock key adc result strobe, and asynchronous key and mic detect levels.
*/
`include "hkc_keyscan_regs.svh"

module hkc_keyscan #(
  parameter int unsigned SETTLE_STEP_CYC = `HKC_SETTLE_STEP_CYC,
  parameter int unsigned MASK_STEP_CYC = `HKC_MASK_STEP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_key_short,
  input wire logic i_mic_present,
  input wire logic i_adc_valid,
  input wire logic [9:0] i_adc_data,
  input wire logic i_meas_valid,
  input wire logic [15:0] i_term_ohm,
  input wire logic [15:0] i_load_ohm,
  input wire logic i_button_event_irq_enable,
  input wire logic i_button_event_clr,
  input wire logic i_mic_removed_clr,
  output logic o_button_event_flag,
  output logic o_mic_removed_flag,
  output logic o_irq,
  output logic o_key_press,
  output logic o_term_short,
  output logic o_load_line_out
);

  // ****************************************
  // functions
  // ****************************************
  function automatic hkc_pkg::hkc_value_t compress(input logic [9:0] adc);
    hkc_pkg::hkc_value_t v;
    logic [9:0] sum;
    v.scaled = 1'b0;
    v.code = adc[6:0];
    sum = {1'b0, adc[8:0]} + {1'b0, `HKC_ADC_ROUND};
    if (adc >= `HKC_ADC_SCALE_LIMIT) begin
      v.scaled = 1'b1;
      v.code = sum[9] ? `HKC_CODE_MAX : sum[8:2];
    end
    return v;
  endfunction

  function automatic logic below(input logic [15:0] ohm, input logic sel,
                                 input logic [15:0] lo, input logic [15:0] hi);
    return ohm < (sel ? hi : lo);
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] sync1_r, sync2_r, sync3_r, pin_r;
  logic [1:0] sync1_nxt, sync2_nxt, sync3_nxt, pin_nxt;

  always_comb begin
    sync1_nxt = {i_mic_present, i_key_short};
    sync2_nxt = sync1_r;
    sync3_nxt = sync2_r;
    pin_nxt = pin_r;
    for (int b = 0; b < 2; b++) begin
      if (sync2_r[b] == sync3_r[b]) begin
        pin_nxt[b] = sync3_r[b];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
      sync3_r <= 2'h0;
      pin_r <= 2'h0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      sync3_r <= sync3_nxt;
      pin_r <= pin_nxt;
    end
  end

  // ****************************************
  // register bytes
  // ****************************************
  hkc_pkg::hkc_cfg_t cfg_r, cfg_nxt;
  logic [7:0] rsv_zero_r, rsv_zero_nxt;
  logic [7:0] rsv_one_r, rsv_one_nxt;
  logic [7:0] rsv_tune_r, rsv_tune_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  hkc_pkg::hkc_value_t value_r, value_nxt;

  always_comb begin
    cfg_nxt = cfg_r;
    rsv_zero_nxt = rsv_zero_r;
    rsv_one_nxt = rsv_one_r;
    rsv_tune_nxt = rsv_tune_r;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        `HKC_OFS_RSV_ZERO: rsv_zero_nxt = i_reg_wdata;
        `HKC_OFS_RSV_ONE: rsv_one_nxt = i_reg_wdata;
        `HKC_OFS_RSV_TUNE: rsv_tune_nxt = i_reg_wdata;
        `HKC_OFS_SETTLE: cfg_nxt.settle = i_reg_wdata;
        `HKC_OFS_MASK: cfg_nxt.mask = i_reg_wdata;
        `HKC_OFS_IMP_CFG: begin
          cfg_nxt.short_sel = i_reg_wdata[`HKC_IMP_SHORT_BIT];
          cfg_nxt.load_sel = i_reg_wdata[`HKC_IMP_LOAD_BIT];
        end
        default: ;
      endcase
    end
    unique case (i_reg_addr)
      `HKC_OFS_RSV_ZERO: rdata_nxt = rsv_zero_r;
      `HKC_OFS_RSV_ONE: rdata_nxt = rsv_one_r;
      `HKC_OFS_RSV_TUNE: rdata_nxt = rsv_tune_r;
      `HKC_OFS_SETTLE: rdata_nxt = cfg_r.settle;
      `HKC_OFS_MASK: rdata_nxt = cfg_r.mask;
      `HKC_OFS_VALUE: rdata_nxt = value_r;
      `HKC_OFS_IMP_CFG: rdata_nxt = {cfg_r.short_sel, cfg_r.load_sel, 6'h00};
      default: rdata_nxt = `HKC_RST_BYTE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_r <= '0;
      rsv_zero_r <= `HKC_RST_BYTE;
      rsv_one_r <= `HKC_RST_BYTE;
      rsv_tune_r <= `HKC_RST_BYTE;
      rdata_r <= `HKC_RST_BYTE;
    end else begin
      cfg_r <= cfg_nxt;
      rsv_zero_r <= rsv_zero_nxt;
      rsv_one_r <= rsv_one_nxt;
      rsv_tune_r <= rsv_tune_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;

  // ****************************************
  // press settle
  // ****************************************
  logic press_settled;

  hkc_settle #(
    .STEP_CYC(SETTLE_STEP_CYC)
  ) u_settle (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_level(pin_r[0]),
    .i_code(cfg_r.settle),
    .o_level(press_settled)
  );

  // ****************************************
  // press mask timeout and mic check
  // ****************************************
  hkc_pkg::hkc_state_t state_r, state_nxt;
  logic [15:0] mcyc_r, mcyc_nxt;
  logic [7:0] mstep_r, mstep_nxt;
  logic btn_flag_r, btn_flag_nxt;
  logic rem_flag_r, rem_flag_nxt;
  logic press_r, press_nxt;
  logic irq_r, irq_nxt;
  logic expire;
  logic settled_d_r, settled_d_nxt;

  always_comb begin
    state_nxt = state_r;
    mcyc_nxt = mcyc_r;
    mstep_nxt = mstep_r;
    press_nxt = 1'b0;
    expire = 1'b0;
    settled_d_nxt = press_settled;
    btn_flag_nxt = btn_flag_r & ~i_button_event_clr;
    rem_flag_nxt = rem_flag_r & ~i_mic_removed_clr;
    unique case (state_r)
      hkc_pkg::HKC_IDLE: begin
        mcyc_nxt = 16'h0000;
        mstep_nxt = 8'h00;
        if (press_settled && !settled_d_r) begin
          state_nxt = hkc_pkg::HKC_MASKING;
        end
      end
      hkc_pkg::HKC_MASKING: begin
        if (mcyc_r == 16'(MASK_STEP_CYC - 1)) begin
          mcyc_nxt = 16'h0000;
          if (mstep_r == cfg_r.mask) begin
            expire = 1'b1;
          end else begin
            mstep_nxt = mstep_r + 8'h01;
          end
        end else begin
          mcyc_nxt = mcyc_r + 16'h0001;
        end
        if (expire) begin
          if (pin_r[1]) begin
            btn_flag_nxt = 1'b1;
            state_nxt = hkc_pkg::HKC_HELD;
          end else begin
            rem_flag_nxt = 1'b1;
            state_nxt = hkc_pkg::HKC_IDLE;
          end
        end
      end
      hkc_pkg::HKC_HELD: begin
        press_nxt = press_settled & pin_r[1];
        if (!press_settled || !pin_r[1]) begin
          state_nxt = hkc_pkg::HKC_IDLE;
        end
      end
    endcase
    if (state_r != hkc_pkg::HKC_HELD) begin
      press_nxt = 1'b0;
    end
    irq_nxt = (btn_flag_nxt & i_button_event_irq_enable) | rem_flag_nxt;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= hkc_pkg::HKC_IDLE;
      mcyc_r <= 16'h0000;
      mstep_r <= 8'h00;
      btn_flag_r <= `HKC_RST_BIT;
      rem_flag_r <= `HKC_RST_BIT;
      press_r <= 1'b0;
      irq_r <= 1'b0;
      settled_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mcyc_r <= mcyc_nxt;
      mstep_r <= mstep_nxt;
      btn_flag_r <= btn_flag_nxt;
      rem_flag_r <= rem_flag_nxt;
      press_r <= press_nxt;
      irq_r <= irq_nxt;
      settled_d_r <= settled_d_nxt;
    end
  end

  assign o_button_event_flag = btn_flag_r;
  assign o_mic_removed_flag = rem_flag_r;
  assign o_key_press = press_r;
  assign o_irq = irq_r;

  // ****************************************
  // key value capture and impedance compare
  // ****************************************
  logic term_short_r, term_short_nxt;
  logic line_out_r, line_out_nxt;

  always_comb begin
    value_nxt = value_r;
    term_short_nxt = term_short_r;
    line_out_nxt = line_out_r;
    if (i_adc_valid && press_settled) begin
      value_nxt = compress(i_adc_data);
    end
    if (i_meas_valid) begin
      term_short_nxt = below(i_term_ohm, cfg_r.short_sel,
                             `HKC_SHORT_OHM_LO, `HKC_SHORT_OHM_HI);
      line_out_nxt = ~below(i_load_ohm, cfg_r.load_sel,
                            `HKC_LOAD_OHM_LO, `HKC_LOAD_OHM_HI);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      value_r <= '0;
      term_short_r <= 1'b0;
      line_out_r <= 1'b0;
    end else begin
      value_r <= value_nxt;
      term_short_r <= term_short_nxt;
      line_out_r <= line_out_nxt;
    end
  end

  assign o_term_short = term_short_r;
  assign o_load_line_out = line_out_r;

endmodule // hkc_keyscan

// ---- hkc_keyscan_regs.svh ----
/*
  register offsets, field positions, reset values and timing counts for the keyscan block.
  assumes a 50 mhz core clock; included by its bare name.
*/
`ifndef HKC_KEYSCAN_REGS_SVH
`define HKC_KEYSCAN_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define HKC_OFS_RSV_ZERO 8'h11
`define HKC_OFS_RSV_ONE 8'h12
`define HKC_OFS_RSV_TUNE 8'h13
`define HKC_OFS_RSV_RO 8'h14
`define HKC_OFS_SETTLE 8'h15
`define HKC_OFS_MASK 8'h16
`define HKC_OFS_VALUE 8'h17
`define HKC_OFS_IMP_CFG 8'h18

// ****************************************
// reset values and field positions
// ****************************************
`define HKC_RST_BYTE 8'h00
`define HKC_RST_BIT 1'b0
`define HKC_RST_CODE 7'h00
`define HKC_VALUE_SCALED_BIT 7
`define HKC_IMP_SHORT_BIT 7
`define HKC_IMP_LOAD_BIT 6
`define HKC_ADC_SCALE_LIMIT 10'h080
`define HKC_ADC_ROUND 9'h002
`define HKC_CODE_MAX 7'h7f

// ****************************************
// impedance thresholds in ohms
// ****************************************
`define HKC_SHORT_OHM_LO 16'h0004
`define HKC_SHORT_OHM_HI 16'h0007
`define HKC_LOAD_OHM_LO 16'h02bc
`define HKC_LOAD_OHM_HI 16'h05dc

// ****************************************
// timing
// ****************************************
`define HKC_CLK_PERIOD_NS 20
`define HKC_SETTLE_STEP_NS 250000
`define HKC_MASK_STEP_NS 1000000
`define HKC_SETTLE_STEP_CYC (`HKC_SETTLE_STEP_NS / `HKC_CLK_PERIOD_NS)
`define HKC_MASK_STEP_CYC (`HKC_MASK_STEP_NS / `HKC_CLK_PERIOD_NS)

`endif

// ---- hkc_pkg.sv ----
/*
  types shared by the keyscan block.
  assumes nothing beyond a systemverilog compiler.
*/
package hkc_pkg;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [7:0] settle;
    logic [7:0] mask;
    logic short_sel;
    logic load_sel;
  } hkc_cfg_t;

  typedef struct packed {
    logic scaled;
    logic [6:0] code;
  } hkc_value_t;

  typedef enum logic [1:0] {
    HKC_IDLE,
    HKC_MASKING,
    HKC_HELD
  } hkc_state_t;

endpackage

// ---- hkc_settle.sv ----
/*
  press settle filter: passes a level change only after it stood for (code + 1) steps.
  assumes a synchronised input level and a synchronous active-low reset.
*/
module hkc_settle #(
  parameter int unsigned STEP_CYC = 12500
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_level,
  input wire logic [7:0] i_code,
  output logic o_level
);

  // ****************************************
  // settle counters
  // ****************************************
  logic [15:0] cyc_r, cyc_nxt;
  logic [7:0] step_r, step_nxt;
  logic level_r, level_nxt;

  always_comb begin
    cyc_nxt = cyc_r;
    step_nxt = step_r;
    level_nxt = level_r;
    if (i_level == level_r) begin
      cyc_nxt = 16'h0000;
      step_nxt = 8'h00;
    end else if (cyc_r == 16'(STEP_CYC - 1)) begin
      cyc_nxt = 16'h0000;
      if (step_r == i_code) begin
        level_nxt = i_level;
        step_nxt = 8'h00;
      end else begin
        step_nxt = step_r + 8'h01;
      end
    end else begin
      cyc_nxt = cyc_r + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cyc_r <= 16'h0000;
      step_r <= 8'h00;
      level_r <= 1'b0;
    end else begin
      cyc_r <= cyc_nxt;
      step_r <= step_nxt;
      level_r <= level_nxt;
    end
  end

  assign o_level = level_r;

endmodule // hkc_settle

// ---- hkc_keyscan_props.sv ----
/*
  port checker for hkc_keyscan.
  bound to every hkc_keyscan instance; sees its ports only.
*/
module hkc_keyscan_props (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_meas_valid,
  input wire logic [15:0] i_term_ohm,
  input wire logic [15:0] i_load_ohm,
  input wire logic i_button_event_irq_enable,
  input wire logic i_button_event_clr,
  input wire logic o_button_event_flag,
  input wire logic o_mic_removed_flag,
  input wire logic o_irq,
  input wire logic o_key_press,
  input wire logic o_term_short,
  input wire logic o_load_line_out
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ****
  // shadow of the threshold selects
  // ****
  logic sh_r;
  logic ld_r;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sh_r <= 1'b0;
      ld_r <= 1'b0;
    end else if (i_reg_wr && i_reg_addr == 8'h18) begin
      sh_r <= i_reg_wdata[7];
      ld_r <= i_reg_wdata[6];
    end
  end
  a_rw_readback: assert property ((i_reg_wr && i_reg_addr inside {8'h11, 8'h12, 8'h13, 8'h15, 8'h16})
    ##1 (!i_reg_wr && i_reg_addr == $past(i_reg_addr)) |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("register readback differs");
  a_ro_zero: assert property (!(i_reg_addr inside {[8'h11:8'h13], [8'h15:8'h18]}) |=> o_reg_rdata == 8'h00)
    else $error("unmapped or read-only byte not zero");
  a_cfg_read: assert property (i_reg_addr == 8'h18 && !i_reg_wr |=> o_reg_rdata == {sh_r, ld_r, 6'h00})
    else $error("threshold select byte wrong");
  a_short_cmp: assert property (i_meas_valid && !i_reg_wr |=>
    o_term_short == ($past(i_term_ohm) < (sh_r ? 16'h0007 : 16'h0004)))
    else $error("short compare wrong");
  a_load_cmp: assert property (i_meas_valid && !i_reg_wr |=>
    o_load_line_out == ($past(i_load_ohm) >= (ld_r ? 16'h05dc : 16'h02bc)))
    else $error("load class wrong");
  a_irq_map: assert property (o_irq == ((o_button_event_flag && $past(i_button_event_irq_enable))
    || o_mic_removed_flag))
    else $error("irq mapping wrong");
  a_remove_nopress: assert property ($rose(o_mic_removed_flag) |-> !o_key_press)
    else $error("press with removal");
  a_btn_sticky: assert property (o_button_event_flag && !i_button_event_clr |=> o_button_event_flag)
    else $error("button flag lost");
  a_btn_clear: assert property ($fell(o_button_event_flag) |-> $past(i_button_event_clr))
    else $error("button flag fell unasked");
  a_press_flag: assert property ($rose(o_key_press) |-> o_button_event_flag || $past(o_button_event_flag))
    else $error("press without button flag");
endmodule // hkc_keyscan_props

bind hkc_keyscan hkc_keyscan_props u_hkc_keyscan_props (.*);

// ---- hkc_headset_model.sv ----
/*
  plugged headset model: key short, mic presence and key adc strobes.
  assumes the bench calls its tasks; drives on rising edges.
*/
module hkc_headset_model (
  input wire logic i_clk,
  output logic o_key_short,
  output logic o_mic_present,
  output logic o_adc_valid,
  output logic [9:0] o_adc_data
);
  initial begin
    o_key_short = 1'b0;
    o_mic_present = 1'b1;
    o_adc_valid = 1'b0;
    o_adc_data = 10'h155;
  end
  task automatic key(input logic lvl, input int hold);
    @(posedge i_clk);
    o_key_short <= lvl;
    repeat (hold) @(posedge i_clk);
  endtask
  task automatic mic(input logic lvl);
    @(posedge i_clk);
    o_mic_present <= lvl;
  endtask
  // data line scrambled outside the strobe
  task automatic adc(input logic [9:0] v);
    @(posedge i_clk);
    o_adc_valid <= 1'b1;
    o_adc_data <= v;
    @(posedge i_clk);
    o_adc_valid <= 1'b0;
    o_adc_data <= ~v;
  endtask
endmodule // hkc_headset_model

// ---- tb.sv ----
/*
  self-checking bench for hkc_keyscan with a headset model.
  assumes short step counts for settle and mask timing.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 4;
  localparam int MC = 8;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_meas_valid = 1'b0;
  logic [15:0] i_term_ohm = 16'h0000;
  logic [15:0] i_load_ohm = 16'h0000;
  logic i_button_event_irq_enable = 1'b0;
  logic i_button_event_clr = 1'b0;
  logic i_mic_removed_clr = 1'b0;
  logic [7:0] o_reg_rdata;
  logic i_key_short, i_mic_present, i_adc_valid;
  logic [9:0] i_adc_data;
  logic o_button_event_flag, o_mic_removed_flag, o_irq, o_key_press, o_term_short, o_load_line_out;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int v = 0;
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) cyc++;
  hkc_keyscan #(.SETTLE_STEP_CYC(SC), .MASK_STEP_CYC(MC)) u_hkc_keyscan (.*);
  hkc_headset_model u_hkc_headset_model (.i_clk(i_clk), .o_key_short(i_key_short),
    .o_mic_present(i_mic_present), .o_adc_valid(i_adc_valid), .o_adc_data(i_adc_data));
  // ****
  // shared tasks
  // ****
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wr <= 1'b1;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_reg_addr <= a;
    @(posedge i_clk);
    #1 chk("rdata", {8'h00, e}, {8'h00, o_reg_rdata});
  endtask
  task automatic clr_flags;
    @(posedge i_clk);
    i_button_event_clr <= 1'b1;
    i_mic_removed_clr <= 1'b1;
    @(posedge i_clk);
    i_button_event_clr <= 1'b0;
    i_mic_removed_clr <= 1'b0;
  endtask
  // one press, mic kept or pulled during the mask
  task automatic press(input logic present, input logic en);
    int s, m, exp, t0, n;
    logic early;
    logic [9:0] a;
    s = $urandom % 3;
    m = $urandom % 3 + (present ? 0 : 2);
    early = 1'b0;
    wr(8'h15, 8'(s));
    wr(8'h16, 8'(m));
    @(posedge i_clk);
    i_button_event_irq_enable <= en;
    u_hkc_headset_model.key(1'b1, 1);
    u_hkc_headset_model.key(1'b0, 8);
    exp = (s + 1) * SC + (m + 1) * MC;
    u_hkc_headset_model.key(1'b1, 0);
    t0 = cyc;
    if (!present) begin
      repeat ((s + 1) * SC + 8) @(posedge i_clk);
      u_hkc_headset_model.mic(1'b0);
    end
    for (n = 0; n < 400; n++) begin
      @(posedge i_clk);
      #1;
      if ((present ? o_button_event_flag : o_mic_removed_flag) === 1'b1) break;
      early |= (o_key_press === 1'b1);
    end
    chk("early_press", 16'h0000, 16'(early));
    chk("delay", 16'h0001, 16'(cyc - t0 >= exp && cyc - t0 <= exp + 12));
    repeat (3) @(posedge i_clk);
    #1 chk("press", 16'(present), 16'(o_key_press));
    chk("irq", 16'(present ? en : 1'b1), 16'(o_irq));
    chk("flags", 16'({present, !present}), 16'({o_button_event_flag, o_mic_removed_flag}));
    for (int j = 0; j < 4 && present; j++) begin
      a = (j == 0) ? 10'h1ff : (j == 1) ? 10'($urandom % 128) : (j == 2) ? 10'h080 : 10'(128 + $urandom % 896);
      u_hkc_headset_model.adc(a);
      v = (a < 128) ? a : 128 + ((a % 512 + 2) / 4 > 127 ? 127 : (a % 512 + 2) / 4);
      rdchk(8'h17, 8'(v));
    end
    u_hkc_headset_model.key(1'b0, (s + 1) * SC + 8);
    u_hkc_headset_model.mic(1'b1);
    clr_flags();
    repeat (10) @(posedge i_clk);
    #1 chk("idle", 16'h0000, 16'({o_button_event_flag, o_mic_removed_flag, o_irq, o_key_press}));
    rdchk(8'h17, 8'(v));
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    int t, l;
    void'($urandom(32'hcb95));
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int k = 16; k < 26; k++) rdchk(8'(k), 8'h00);
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h01);
    wr(8'h13, 8'h45);
    wr(8'h14, 8'h5a);
    wr(8'h17, 8'h5a);
    rdchk(8'h12, 8'h01);
    rdchk(8'h13, 8'h45);
    rdchk(8'h14, 8'h00);
    rdchk(8'h17, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(8'h18, {2'(k), 6'h3f});
      rdchk(8'h18, {2'(k), 6'h00});
      for (int j = 0; j < 6; j++) begin
        t = (j < 4) ? 3 + j + (j > 1) : $urandom % 16;
        l = (j < 4) ? 699 + j % 2 + 800 * (j > 1) : $urandom % 2000;
        @(posedge i_clk);
        i_meas_valid <= 1'b1;
        i_term_ohm <= 16'(t);
        i_load_ohm <= 16'(l);
        @(posedge i_clk);
        i_meas_valid <= 1'b0;
        #1 chk("term_short", 16'(t < (k / 2 ? 7 : 4)), 16'(o_term_short));
        chk("line_out", 16'(l >= (k % 2 ? 1500 : 700)), 16'(o_load_line_out));
      end
    end
    press(1'b1, 1'b1);
    press(1'b1, 1'b0);
    press(1'b0, 1'b1);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    complete_run();
  end
endmodule // tb
